/* include/ivp_pkg.sv */
// Package: register map, field layout and carrier types of the vector priority block
package ivp_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] CORE_PRIO_OFS  = 8'h00; // Core source priority
  localparam logic [7:0] PERI_PRIO_OFS  = 8'h04; // Peripheral source priority
  localparam logic [7:0] VEC_BASE_OFS   = 8'h08; // Vector base
  localparam logic [7:0] STATUS_OFS     = 8'h0C; // Sticky event status
  localparam logic [7:0] MASK_OFS       = 8'h10; // Event mask
  localparam logic [7:0] VEC_READ_OFS   = 8'h14; // Current forwarded vector
  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int         DW             = 24;      // Register width
  localparam int         NSRC           = 37;      // Sources, NMI last
  localparam int         SRCW           = 6;       // Source index width
  localparam logic [23:0] PRIO_RST      = 24'h000000; // All programmable sources disabled
  localparam logic [23:0] VEC_BASE_RST  = 24'h000000;
  localparam logic [1:0]  EVT_RST       = 2'h0;
  localparam logic [23:0] PERI_RW_MASK  = 24'h0003FF; // Bits 23..10 read zero
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int XFER_CHAN0_POS  = 12; // Channel n at 12 + 2n, ch5 at 23..22
  localparam int EXT_MODE_W      = 3;  // Mode field width, request a at 2..0
  localparam int HOST_PORT_POS   = 0;
  localparam int SYNC_SER0_POS   = 2;
  localparam int SYNC_SER1_POS   = 4;
  localparam int ASYNC_SER_POS   = 6;
  localparam int TIMER_POS       = 8;
  localparam int EVT_OVERRUN     = 0; // Event while already pending
  localparam int EVT_DISABLED    = 1; // Event from a disabled source
  // ----------------------------------------------------------------
  // Source groups: first index and first vector offset
  // ----------------------------------------------------------------
  localparam int SRC_EXT = 0;   localparam logic [7:0] OFS_EXT   = 8'h10;
  localparam int SRC_XFR = 4;   localparam logic [7:0] OFS_XFR   = 8'h18;
  localparam int SRC_TMR = 10;  localparam logic [7:0] OFS_TMR   = 8'h24;
  localparam int SRC_SS0 = 16;  localparam logic [7:0] OFS_SS0   = 8'h30;
  localparam int SRC_SS1 = 22;  localparam logic [7:0] OFS_SS1   = 8'h40;
  localparam int SRC_ASY = 28;  localparam logic [7:0] OFS_ASY   = 8'h50;
  localparam int SRC_HST = 33;  localparam logic [7:0] OFS_HST   = 8'h60;
  localparam int SRC_NMI = 36;  localparam logic [7:0] OFS_NMI   = 8'h0C;
  localparam logic [1:0] LVL_NMI = 2'h3; // Non-maskable level
  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic            valid; // A request is forwarded
    logic [1:0]      level; // Its priority level
    logic [SRCW-1:0] src;   // Its source index
    logic [DW-1:0]   addr;  // Vector address
  } vec_req_s;
  typedef struct packed {
    logic       wr;    // Write strobe
    logic       rd;    // Read strobe
    logic [7:0] addr;  // Byte address
    logic [23:0] wdata; // Write data
  } reg_req_s;
endpackage : ivp_pkg

/* design/ivp_top.sv */
// Interrupt vector priority: register file, pending sources and level arbiter
`timescale 1ns/1ns
// How it works
// - Vector address is base plus source offset.
// - Async serial vectors at 0x50 to 0x58.
// - Host port vectors at 0x60, 0x62, 0x64.
// - Second sync serial last slot at 0x4A.
// - Free offsets never claimed by a source.
// - Level 3 unmaskable highest, level 0 lowest.
// - Core register: channel levels, request mode fields.
// - Peripheral register bits 23..10 read zero.
// - Timer level in peripheral bits 9..8.
// - Async serial level in bits 7..6.
// - Second sync serial level in bits 5..4.
// - First sync serial level in bits 3..2.
// - Host port level in bits 1..0.
// - Each channel own field, channel five top.
module ivp_top (
  input  wire logic                    i_clk,       // 100 MHz
  input  wire logic                    i_rst,       // Sync, active high
  input  wire logic                    i_reg_wr,    // Write strobe
  input  wire logic                    i_reg_rd,    // Read strobe
  input  wire logic [7:0]              i_reg_addr,  // Byte address
  input  wire logic [23:0]             i_reg_wdata, // Write data
  output logic      [23:0]             o_reg_rdata, // Read data, next cycle
  input  wire logic [ivp_pkg::NSRC-2:0] i_src_event, // Source event pulses
  input  wire logic                    i_nmi_event, // Non-maskable pulse
  input  wire logic [1:0]              i_core_mask, // Current core mask
  input  wire logic                    i_vec_ack,   // Core took the vector
  output logic                         o_vec_valid, // Request forwarded
  output logic      [1:0]              o_vec_level, // Its level
  output logic      [23:0]             o_vec_addr,  // Its vector address
  output logic                         o_irq        // Unmasked event status
);
  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Fixed offset of a source: group base plus two per member
  // Groups tested from the top down, two bounds each but the last;
  // anything left over keeps the non-maskable slot
  function automatic logic [7:0] src_offset(input int i);
    logic [7:0] ofs;
    ofs = ivp_pkg::OFS_NMI;
    // Host port: three members
    if (i >= ivp_pkg::SRC_HST && i < ivp_pkg::SRC_NMI)
      ofs = ivp_pkg::OFS_HST + 8'(2 * (i - ivp_pkg::SRC_HST));
    // Async serial port: five members
    else if (i >= ivp_pkg::SRC_ASY && i < ivp_pkg::SRC_HST)
      ofs = ivp_pkg::OFS_ASY + 8'(2 * (i - ivp_pkg::SRC_ASY));
    // Second sync serial port, last slot on top
    else if (i >= ivp_pkg::SRC_SS1 && i < ivp_pkg::SRC_ASY)
      ofs = ivp_pkg::OFS_SS1 + 8'(2 * (i - ivp_pkg::SRC_SS1));
    // First sync serial port
    else if (i >= ivp_pkg::SRC_SS0 && i < ivp_pkg::SRC_SS1)
      ofs = ivp_pkg::OFS_SS0 + 8'(2 * (i - ivp_pkg::SRC_SS0));
    // Timer compare and overflow pairs
    else if (i >= ivp_pkg::SRC_TMR && i < ivp_pkg::SRC_SS0)
      ofs = ivp_pkg::OFS_TMR + 8'(2 * (i - ivp_pkg::SRC_TMR));
    // Transfer channels zero to five
    else if (i >= ivp_pkg::SRC_XFR && i < ivp_pkg::SRC_TMR)
      ofs = ivp_pkg::OFS_XFR + 8'(2 * (i - ivp_pkg::SRC_XFR));
    // External requests a to d
    else if (i < ivp_pkg::SRC_XFR)
      ofs = ivp_pkg::OFS_EXT + 8'(2 * i);
    // No group reaches the free slots
    return ofs;
  endfunction : src_offset

  // Priority field of a source; zero means disabled
  // Mode fields: only the low two bits act as a level;
  // the third bit is stored and read back only
  function automatic logic [1:0] src_field(input int i, input logic [23:0] c,
                                           input logic [23:0] p);
    logic [1:0] f;
    f = 2'h0;
    // External request mode fields
    if (i < ivp_pkg::SRC_XFR)
      f = c[ivp_pkg::EXT_MODE_W*i +: 2];
    // Transfer channel pairs
    else if (i < ivp_pkg::SRC_TMR)
      f = c[ivp_pkg::XFER_CHAN0_POS + 2*(i - ivp_pkg::SRC_XFR) +: 2];
    // Timer field
    else if (i < ivp_pkg::SRC_SS0)
      f = p[ivp_pkg::TIMER_POS +: 2];
    // First sync serial field
    else if (i < ivp_pkg::SRC_SS1)
      f = p[ivp_pkg::SYNC_SER0_POS +: 2];
    // Second sync serial field
    else if (i < ivp_pkg::SRC_ASY)
      f = p[ivp_pkg::SYNC_SER1_POS +: 2];
    // Async serial field
    else if (i < ivp_pkg::SRC_HST)
      f = p[ivp_pkg::ASYNC_SER_POS +: 2];
    // Host port field
    else if (i < ivp_pkg::SRC_NMI)
      f = p[ivp_pkg::HOST_PORT_POS +: 2];
    // Non-maskable source keeps zero, enabled apart
    return f;
  endfunction : src_field

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  // Field value n gives level n-1, so a cleared
  // field costs no extra enable bit per source
  logic [23:0]                core_source_priority;       // Core sources
  logic [23:0]                peripheral_source_priority; // Peripherals
  logic [23:0]                vector_base;                // Table base
  logic [1:0]                 evt_status;                 // Sticky events
  logic [1:0]                 evt_mask;                   // Event enables
  logic [ivp_pkg::NSRC-1:0]   pending;                    // Latched requests
  logic [ivp_pkg::NSRC-1:0]   ack_clr;                    // Cleared by ack
  logic [ivp_pkg::NSRC-1:0]   src_on;                     // Field non-zero
  logic [ivp_pkg::NSRC-1:0]   all_evt;                    // Events incl. NMI
  logic [1:0]                 evt_set;                    // New events
  ivp_pkg::reg_req_s          req;                        // Bus request
  ivp_pkg::vec_req_s          cur;                        // Forwarded vector
  ivp_pkg::vec_req_s          next_cur;                   // Arbiter result

  assign req     = '{wr: i_reg_wr, rd: i_reg_rd, addr: i_reg_addr,
                     wdata: i_reg_wdata};
  assign all_evt = {i_nmi_event, i_src_event};

  // ----------------------------------------------------------------
  // Priority register writes
  // ----------------------------------------------------------------
  // Core writes set every core source level; reset disables all programmable sources
  // Peripheral bits 23..10 never stored, so read zero
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      core_source_priority       <= ivp_pkg::PRIO_RST;
      peripheral_source_priority <= ivp_pkg::PRIO_RST;
    end else if (req.wr) begin
      if (req.addr == ivp_pkg::CORE_PRIO_OFS)
        core_source_priority <= req.wdata;
      if (req.addr == ivp_pkg::PERI_PRIO_OFS)
        peripheral_source_priority <= req.wdata & ivp_pkg::PERI_RW_MASK;
    end
  end

  // Vector base register
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      vector_base <= ivp_pkg::VEC_BASE_RST;
    end else if (req.wr && req.addr == ivp_pkg::VEC_BASE_OFS) begin
      vector_base <= req.wdata;
    end
  end

  // ----------------------------------------------------------------
  // Pending sources
  // ----------------------------------------------------------------
  // Enable map and the bit the core's acknowledge retires
  always_comb begin
    src_on  = '0;
    ack_clr = '0;
    for (int i = 0; i < ivp_pkg::NSRC; i++) begin
      src_on[i] = (i == ivp_pkg::SRC_NMI) ||
                  (src_field(i, core_source_priority,
                             peripheral_source_priority) != 2'h0);
    end
    // Only the shown source is retired by a take
    if (i_vec_ack && cur.valid)
      ack_clr[cur.src] = 1'b1;
  end

  // Events latch on enabled sources; a new event beats the ack clear
  // A source disabled while pending keeps its bit but
  // leaves arbitration until its field is set again
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pending <= '0;
    end else begin
      pending <= (pending & ~ack_clr) | (all_evt & src_on);
    end
  end

  // ----------------------------------------------------------------
  // Arbiter
  // ----------------------------------------------------------------
  // Highest eligible level wins; lower index wins a tie
  // One pass: a later source replaces the holder only
  // on a strictly higher level, giving index order.
  // Long chain; register the pending map if tight
  always_comb begin
    logic [1:0]                lvl;
    logic [ivp_pkg::NSRC-1:0]  live;
    lvl      = 2'h0;
    live     = pending & ~ack_clr & src_on;
    next_cur = '0;
    for (int i = 0; i < ivp_pkg::NSRC; i++) begin
      // Field n means level n-1; NMI stands alone at level 3
      if (i == ivp_pkg::SRC_NMI)
        lvl = ivp_pkg::LVL_NMI;
      else
        lvl = src_field(i, core_source_priority,
                        peripheral_source_priority) - 2'h1;
      // Core mask never holds back the top level
      if (live[i] && (lvl >= i_core_mask || lvl == ivp_pkg::LVL_NMI) &&
          (!next_cur.valid || lvl > next_cur.level)) begin
        next_cur.valid = 1'b1;
        next_cur.level = lvl;
        next_cur.src   = ivp_pkg::SRCW'(i);
        next_cur.addr  = vector_base + {16'h0000, src_offset(i)};
      end
    end
  end

  // Forwarded request held in flops toward the core
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  // Outputs straight from the forwarded-vector flops
  assign o_vec_valid = cur.valid;
  assign o_vec_level = cur.level;
  assign o_vec_addr  = cur.addr;

  // ----------------------------------------------------------------
  // Event status, mask and interrupt
  // ----------------------------------------------------------------
  // Overrun: event on a pending source; disabled: event dropped
  // A repeat merges into one vector, so it is flagged
  always_comb begin
    evt_set = ivp_pkg::EVT_RST;
    evt_set[ivp_pkg::EVT_OVERRUN]  = |(all_evt & pending & ~ack_clr);
    evt_set[ivp_pkg::EVT_DISABLED] = |(all_evt & ~src_on);
  end

  // Write one clears; a same-cycle set wins
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      evt_status <= ivp_pkg::EVT_RST;
    end else if (req.wr && req.addr == ivp_pkg::STATUS_OFS) begin
      // Clear written ones, then add new sets
      evt_status <= (evt_status & ~req.wdata[1:0]) | evt_set;
    end else begin
      // No clear: sets only
      evt_status <= evt_status | evt_set;
    end
  end

  // Mask register
  // Mask bits line up with the status bits
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      evt_mask <= ivp_pkg::EVT_RST;
    end else if (req.wr && req.addr == ivp_pkg::MASK_OFS) begin
      evt_mask <= req.wdata[1:0];
    end
  end

  // Registered level interrupt, one cycle behind the status
  // The lag keeps o_irq a plain flop output
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(evt_status & evt_mask);
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  // Data stand only in the cycle after the strobe; unmapped reads zero
  // Zero between reads lets several slaves be or-ed
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_reg_rdata <= 24'h000000;
    end else if (req.rd) begin
      unique case (req.addr)
        ivp_pkg::CORE_PRIO_OFS: o_reg_rdata <= core_source_priority;
        ivp_pkg::PERI_PRIO_OFS: o_reg_rdata <= peripheral_source_priority;
        ivp_pkg::VEC_BASE_OFS:  o_reg_rdata <= vector_base;
        ivp_pkg::STATUS_OFS:    o_reg_rdata <= {22'h000000, evt_status};
        ivp_pkg::MASK_OFS:      o_reg_rdata <= {22'h000000, evt_mask};
        ivp_pkg::VEC_READ_OFS:  o_reg_rdata <= cur.addr;
        default:                o_reg_rdata <= 24'h000000;
      endcase
    end else begin
      o_reg_rdata <= 24'h000000;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic [7:0] cur_ofs; // Offset part of the forwarded address
  assign cur_ofs = 8'(cur.addr - vector_base);

  sequence s_base_write;
    req.wr && req.addr == ivp_pkg::VEC_BASE_OFS;
  endsequence

  // Vectors after a base write use the new base
  a_vec_base_add: assert property (@(posedge i_clk) disable iff (i_rst)
    s_base_write ##[1:8] next_cur.valid |->
      next_cur.addr == vector_base + {16'h0000, src_offset(next_cur.src)})
    else $error("vector address is not base plus offset");

  // Async serial members two apart from 0x50
  a_async_offset: assert property (@(posedge i_clk) disable iff (i_rst)
    cur.valid && cur.src >= ivp_pkg::SRC_ASY && cur.src < ivp_pkg::SRC_HST |->
      cur_ofs == 8'h50 + 8'(2 * (cur.src - ivp_pkg::SRC_ASY)))
    else $error("async serial vector offset wrong");

  // Host port members on their three slots
  a_host_offset: assert property (@(posedge i_clk) disable iff (i_rst)
    cur.valid && cur.src >= ivp_pkg::SRC_HST && cur.src < ivp_pkg::SRC_NMI |->
      cur_ofs inside {8'h60, 8'h62, 8'h64})
    else $error("host port vector offset wrong");

  // Last member of the second sync serial group
  a_slot_offset: assert property (@(posedge i_clk) disable iff (i_rst)
    cur.valid && cur.src == ivp_pkg::SRCW'(ivp_pkg::SRC_ASY - 1) |->
      cur_ofs == 8'h4A)
    else $error("last slot vector offset wrong");

  // Free slots stay free
  a_free_offsets: assert property (@(posedge i_clk) disable iff (i_rst)
    cur.valid |-> !(cur_ofs inside {8'h4C, 8'h4E, 8'h5A, 8'h5C, 8'h5E}) &&
      !(cur_ofs >= 8'h66))
    else $error("source claimed a free vector offset");

  // Non-maskable event shown two cycles later
  a_nmi_first: assert property (@(posedge i_clk) disable iff (i_rst)
    i_nmi_event && !i_vec_ack |=> ##1 cur.valid && cur.level == 2'h3)
    else $error("non-maskable request not forwarded first");

  // Reserved peripheral bits read zero
  a_peri_zero: assert property (@(posedge i_clk) disable iff (i_rst)
    req.rd && req.addr == ivp_pkg::PERI_PRIO_OFS |=> o_reg_rdata[23:10] == 14'h0)
    else $error("peripheral reserved bits read non-zero");

  // Winner respects the core mask
  a_win_level: assert property (@(posedge i_clk) disable iff (i_rst)
    next_cur.valid && next_cur.level != 2'h3 |->
      next_cur.level >= i_core_mask && next_cur.level <= 2'h2)
    else $error("forwarded level below core mask");

  // Disabled source dropped and flagged at once
  a_disabled_drop: assert property (@(posedge i_clk) disable iff (i_rst)
    i_src_event[0] && core_source_priority[1:0] == 2'h0 |=>
      !pending[0] && evt_status[ivp_pkg::EVT_DISABLED])
    else $error("disabled source was latched");

  // Reset leaves every programmable source disabled
  a_reset_clear: assert property (@(posedge i_clk)
    $fell(i_rst) |-> core_source_priority == 24'h0 &&
      peripheral_source_priority == 24'h0 && !cur.valid)
    else $error("reset left priorities set");

  // Programmable sources never reach the top level
  a_nmi_only: assert property (@(posedge i_clk) disable iff (i_rst)
    cur.valid && cur.level == ivp_pkg::LVL_NMI |-> cur.src == ivp_pkg::SRCW'(ivp_pkg::SRC_NMI))
    else $error("programmable source at level three");

  sequence s_vec_taken;
    i_vec_ack && cur.valid;
  endsequence

  // A taken source is gone from the output next cycle
  a_ack_retire: assert property (@(posedge i_clk) disable iff (i_rst)
    s_vec_taken |=> !cur.valid || cur.src != $past(cur.src))
    else $error("taken source still shown");

endmodule : ivp_top

/* test/ivp_core_model.sv */
// Core model: takes forwarded vectors after a chosen wait and records them
`timescale 1ns/1ns
module ivp_core_model (
  input  wire logic        i_clk,         // 100 MHz
  input  wire logic        i_rst,         // Sync, active high
  input  wire logic [3:0]  i_delay,       // Cycles to wait before taking
  input  wire logic        i_vec_valid,   // Vector shown
  input  wire logic [1:0]  i_vec_level,   // Its level
  input  wire logic [23:0] i_vec_addr,    // Its address
  output logic             o_vec_ack,     // One-cycle take pulse
  output logic      [23:0] o_taken_addr,  // Address taken last
  output logic      [1:0]  o_taken_level, // Level taken last
  output logic      [7:0]  o_taken_count  // Vectors taken so far
);
  logic [3:0] wait_cnt; // Cycles the shown vector has waited
  // ------------------------------------------------------------
  // Take logic
  // ------------------------------------------------------------
  // Capture on the ack edge itself: a higher request may replace the shown one earlier
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_vec_ack     <= 1'b0;
      wait_cnt      <= 4'h0;
      o_taken_count <= 8'h00;
    end else if (o_vec_ack) begin
      o_vec_ack     <= 1'b0;
      wait_cnt      <= 4'h0;
      o_taken_addr  <= i_vec_addr;
      o_taken_level <= i_vec_level;
      o_taken_count <= o_taken_count + 8'h01;
    end else if (i_vec_valid && wait_cnt >= i_delay) begin
      o_vec_ack <= 1'b1; // Ack only while a vector is shown
    end else if (i_vec_valid) begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule : ivp_core_model

/* test/interrupt_vector_priority_bench.sv */
// Bench: register, vector map, field and priority scenarios of the vector priority block
`timescale 1ns/1ns
module interrupt_vector_priority_bench;
  logic                       i_clk = 1'b0;      // Clock
  logic                       i_rst = 1'b1;      // Reset
  logic                       reg_wr = 1'b0;     // Write strobe
  logic                       reg_rd = 1'b0;     // Read strobe
  logic [7:0]                 reg_addr = 8'h00;  // Register address
  logic [23:0]                reg_wdata = 24'h0; // Write data
  logic [23:0]                reg_rdata;         // Read data
  logic [ivp_pkg::NSRC-2:0]   src_event = '0;    // Source pulses
  logic                       nmi_event = 1'b0;  // Non-maskable pulse
  logic [1:0]                 core_mask = 2'h0;  // Core mask level
  logic [3:0]                 delay = 4'h0;      // Model wait
  logic                       vec_ack, vec_valid, irq;
  logic [1:0]                 vec_level, taken_level;
  logic [23:0]                vec_addr, taken_addr, rd_val;
  logic [7:0]                 taken_count, seen_count = 8'h00;
  int                         bad_count = 0;     // Mismatches
  int                         tests_run = 0;     // Comparisons
  always #5 i_clk = ~i_clk;
  ivp_top dut (.i_clk(i_clk), .i_rst(i_rst), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
    .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .o_reg_rdata(reg_rdata),
    .i_src_event(src_event), .i_nmi_event(nmi_event), .i_core_mask(core_mask),
    .i_vec_ack(vec_ack), .o_vec_valid(vec_valid), .o_vec_level(vec_level),
    .o_vec_addr(vec_addr), .o_irq(irq));
  ivp_core_model core (.i_clk(i_clk), .i_rst(i_rst), .i_delay(delay),
    .i_vec_valid(vec_valid), .i_vec_level(vec_level), .i_vec_addr(vec_addr),
    .o_vec_ack(vec_ack), .o_taken_addr(taken_addr), .o_taken_level(taken_level),
    .o_taken_count(taken_count));
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict
  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [23:0] d);
    @(posedge i_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge i_clk);
    reg_wr <= 1'b0;
  endtask : wr
  // Data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [23:0] d);
    @(posedge i_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge i_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  task automatic fire(input logic [35:0] ev, input logic nmi);
    @(posedge i_clk);
    src_event <= ev;
    nmi_event <= nmi;
    @(posedge i_clk);
    src_event <= '0;
    nmi_event <= 1'b0;
  endtask : fire
  // Bounded wait for the model to take one more vector, then compare it
  task automatic take(input logic [23:0] a, input logic [1:0] l);
    int n;
    n = 0;
    while (taken_count === seen_count && n < 40) begin
      @(posedge i_clk);
      n++;
    end
    if (n >= 40) begin
      bad_count++;
      $display("CHECK FAILED vector wait expected take seen none");
      print_verdict();
    end
    seen_count = taken_count;
    check("vector address", taken_addr, a);
    check("vector level", 24'(taken_level), 24'(l));
  endtask : take
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_regs();
    logic [7:0] ofs [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h20};
    foreach (ofs[i]) begin
      rd(ofs[i], rd_val);
      check("reset value", rd_val, 24'h000000);
    end
    wr(ivp_pkg::CORE_PRIO_OFS, 24'hFFFFFF);
    wr(ivp_pkg::PERI_PRIO_OFS, 24'hFFFFFF);
    wr(8'h20, 24'h123456); // Unmapped write is dropped
    rd(ivp_pkg::CORE_PRIO_OFS, rd_val);
    check("core priority", rd_val, 24'hFFFFFF);
    rd(ivp_pkg::PERI_PRIO_OFS, rd_val);
    check("peripheral priority", rd_val, 24'h0003FF);
    wr(ivp_pkg::CORE_PRIO_OFS, 24'h000000);
    $display("test registers done");
  endtask : t_regs
  // One peripheral field enabled at a time; the other four groups fire disabled
  task automatic t_fields();
    logic [23:0] exp [5] = '{24'h60, 24'h30, 24'h40, 24'h50, 24'h24};
    for (int f = 0; f < 5; f++) begin
      wr(ivp_pkg::PERI_PRIO_OFS, 24'h000003 << (2 * f));
      fire(36'h210410401, 1'b0);
      take(exp[f], 2'h2);
    end
    rd(ivp_pkg::STATUS_OFS, rd_val);
    check("disabled status", rd_val, 24'h000002);
    check("irq masked", 24'(irq), 24'h000000);
    wr(ivp_pkg::MASK_OFS, 24'h000002);
    repeat (2) @(posedge i_clk);
    check("irq raised", 24'(irq), 24'h000001);
    wr(ivp_pkg::STATUS_OFS, 24'h000002);
    repeat (2) @(posedge i_clk);
    check("irq cleared", 24'(irq), 24'h000000);
    rd(ivp_pkg::STATUS_OFS, rd_val);
    check("status cleared", rd_val, 24'h000000);
    $display("test fields done");
  endtask : t_fields
  task automatic t_vectors();
    wr(ivp_pkg::CORE_PRIO_OFS, 24'hC00003);
    fire(36'h1 << 9, 1'b0);
    take(24'h000022, 2'h2);
    fire(36'h1 << 0, 1'b0);
    take(24'h000010, 2'h2);
    wr(ivp_pkg::VEC_BASE_OFS, 24'h001000);
    wr(ivp_pkg::PERI_PRIO_OFS, 24'h0003FF);
    for (int k = 0; k < 5; k++) begin
      fire(36'h1 << (28 + k), 1'b0);
      take(24'h001050 + 24'(2 * k), 2'h2);
    end
    for (int k = 0; k < 3; k++) begin
      fire(36'h1 << (33 + k), 1'b0);
      take(24'h001060 + 24'(2 * k), 2'h2);
    end
    fire(36'h1 << 27, 1'b0);
    take(24'h00104A, 2'h2);
    wr(ivp_pkg::VEC_BASE_OFS, 24'h000000);
    $display("test vectors done");
  endtask : t_vectors
  // Slow core: timer at level 0, async serial at level 1, mask and non-maskable
  task automatic t_priority();
    delay <= 4'h5;
    wr(ivp_pkg::PERI_PRIO_OFS, 24'h000180);
    fire(36'h010000C00, 1'b0);
    take(24'h000050, 2'h1);
    take(24'h000024, 2'h0);
    take(24'h000026, 2'h0);
    core_mask <= 2'h2;
    fire(36'h1 << 28, 1'b0);
    repeat (8) @(posedge i_clk);
    check("masked valid", 24'(vec_valid), 24'h000000);
    fire(36'h1 << 28, 1'b0); // Repeat on a pending source
    rd(ivp_pkg::STATUS_OFS, rd_val);
    check("overrun status", rd_val, 24'h000001);
    fire(36'h0, 1'b1);
    rd(ivp_pkg::VEC_READ_OFS, rd_val);
    check("shown vector", rd_val, 24'h00000C);
    take(24'h00000C, 2'h3);
    core_mask <= 2'h0;
    take(24'h000050, 2'h1);
    $display("test priority done");
  endtask : t_priority
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (8) @(posedge i_clk);
    i_rst <= 1'b0;
    t_regs();
    t_fields();
    t_vectors();
    t_priority();
    print_verdict();
  end
endmodule : interrupt_vector_priority_bench
